/* File: hdl/sasp_spi_port.sv */
// Serial register port of a sensor front end, with result buffer and ready signalling
`timescale 1ns/100ps
`default_nettype none
module sasp_spi_port #(
    parameter int RES_W = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             chip_select_low,
    input  wire logic             serial_clock,
    input  wire logic             serial_data_in,
    output logic                  shared_output_pin_o,
    output logic                  shared_output_pin_oe,
    input  wire logic             result_in_valid,
    input  wire logic [RES_W-1:0] result_in_data,
    output logic                  result_in_ready
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0]                     sync1_r;
    logic [2:0]                     sync2_r;
    logic                           sclk_d_r;
    logic                           cs_s;
    logic                           sclk_s;
    logic                           sdi_s;
    logic                           rise;
    logic                           fall;
    sasp_pkg::sasp_state_e          state_r;
    logic [2:0]                     bit_cnt_r;
    logic [7:0]                     shift_r;
    logic [7:0]                     rx_byte;
    logic                           byte_done;
    logic [7:0]                     inst_r;
    logic [2:0]                     ura_r;
    logic [6:0]                     addr_r;
    logic [6:0]                     start_r;
    logic [6:0]                     span_cnt_r;
    logic [6:0]                     addr_nxt;
    logic [1:0]                     byte_cnt_r;
    logic                           reading_r;
    logic                           load_pend_r;
    logic [7:0]                     tx_r;
    logic [6:0]                     ones_cnt_r;
    logic                           ser_rst_hit;
    logic [7:0]                     mem_r [0:(1<<sasp_pkg::ADDR_W)-1];
    logic                           wr_stb;
    logic                           ser_rst_en;
    logic                           ctrl_stream;
    logic [RES_W-1:0]               buf_r [0:1];
    logic                           wr_ptr_r;
    logic                           rd_ptr_r;
    logic [1:0]                     cnt_r;
    logic [1:0]                     cnt_nxt;
    logic                           push;
    logic                           pop;
    logic [RES_W-1:0]               res_r;
    logic                           res_busy;
    logic                           rd_hi_msb;
    logic                           rd_lo_lsb;
    logic                           ready_low_r;
    logic                           pulse_pend_r;
    logic [15:0]                    pulse_cnt_r;
    logic                           fresh_n_r;

    localparam logic [15:0] PULSE_CYC = 16'(sasp_pkg::READY_PULSE_CYC);
    localparam logic [6:0]  ONES_LAST = 7'(sasp_pkg::SER_RST_ONES - 1);

    // Read value of any register address
    function automatic logic [7:0] reg_read(input logic [6:0] a);
        logic [7:0] v;
        v = mem_r[a];
        if (a == sasp_pkg::RESULT_HI_ADDR) begin
            v = res_r[RES_W-1 -: 8];
        end else if (a == sasp_pkg::RESULT_LO_ADDR) begin
            v = res_r[7:0];
        end else if (a == sasp_pkg::STATUS_ADDR) begin
            v = 8'h00;
            v[sasp_pkg::FRESH_BIT] = fresh_n_r;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers and serial clock edges
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r  <= 3'h1;
            sync2_r  <= 3'h1;
            sclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= {serial_data_in, serial_clock, chip_select_low};
            sync2_r  <= sync1_r;
            sclk_d_r <= sync2_r[1];
        end
    end

    assign cs_s      = sync2_r[0];
    assign sclk_s    = sync2_r[1];
    assign sdi_s     = sync2_r[2];
    assign rise      = ~cs_s & sclk_s & ~sclk_d_r;
    assign fall      = ~cs_s & ~sclk_s & sclk_d_r;
    assign rx_byte   = {shift_r[6:0], sdi_s};
    assign byte_done = rise & (bit_cnt_r == 3'h7);

    // Configuration fields held in registers
    assign ser_rst_en  = (mem_r[sasp_pkg::SER_RST_ADDR] == sasp_pkg::SER_RST_ON);
    assign ctrl_stream = mem_r[sasp_pkg::STREAM_CTRL_ADDR][sasp_pkg::KIND_BIT];
    assign ser_rst_hit = ser_rst_en & rise & sdi_s & (ones_cnt_r >= ONES_LAST);

    // Next address within a transfer
    always_comb begin
        if (ctrl_stream && inst_r[sasp_pkg::SZ_HI:sasp_pkg::SZ_LO] == sasp_pkg::SZ_STREAM
            && span_cnt_r == mem_r[sasp_pkg::STREAM_CTRL_ADDR][sasp_pkg::SPAN_HI:0]) begin
            addr_nxt = start_r;
        end else if (addr_r == sasp_pkg::ADDR_MAX) begin
            addr_nxt = sasp_pkg::ADDR_ZERO;
        end else begin
            addr_nxt = addr_r + sasp_pkg::ADDR_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Serial reset detector
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst || cs_s) begin
            ones_cnt_r <= 7'h00;
        end else if (rise) begin
            if (!sdi_s) begin
                ones_cnt_r <= 7'h00;
            end else if (ones_cnt_r < ONES_LAST) begin
                ones_cnt_r <= ones_cnt_r + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Protocol machine, shifters and address tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            ura_r <= sasp_pkg::URA_RESET;
        end else if (ser_rst_hit) begin
            ura_r <= sasp_pkg::URA_RESET;
        end else if (byte_done && state_r == sasp_pkg::ST_URA && !inst_r[sasp_pkg::INST_READ_BIT]) begin
            ura_r <= rx_byte[sasp_pkg::URA_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst || cs_s || ser_rst_hit) begin
            state_r     <= sasp_pkg::ST_INST;
            bit_cnt_r   <= 3'h0;
            reading_r   <= 1'b0;
            load_pend_r <= 1'b0;
            tx_r        <= 8'h00;
        end else if (rise) begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_done) begin
                case (state_r)
                    sasp_pkg::ST_INST: begin
                        inst_r      <= rx_byte;
                        reading_r   <= rx_byte[sasp_pkg::INST_READ_BIT];
                        load_pend_r <= rx_byte[sasp_pkg::INST_READ_BIT];
                        if (rx_byte[sasp_pkg::INST_URA_BIT]) begin
                            state_r <= sasp_pkg::ST_URA;
                        end else begin
                            addr_r     <= {ura_r, rx_byte[sasp_pkg::LRA_HI:0]};
                            start_r    <= {ura_r, rx_byte[sasp_pkg::LRA_HI:0]};
                            span_cnt_r <= 7'h00;
                            byte_cnt_r <= 2'h0;
                            state_r    <= sasp_pkg::ST_DATA;
                        end
                    end
                    sasp_pkg::ST_URA: begin
                        state_r   <= sasp_pkg::ST_IGNORE;
                        reading_r <= 1'b0;
                    end
                    sasp_pkg::ST_DATA: begin
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        if (inst_r[sasp_pkg::SZ_HI:sasp_pkg::SZ_LO] != sasp_pkg::SZ_STREAM
                            && byte_cnt_r == inst_r[sasp_pkg::SZ_HI:sasp_pkg::SZ_LO]) begin
                            state_r   <= sasp_pkg::ST_IGNORE;
                            reading_r <= 1'b0;
                        end else begin
                            addr_r      <= addr_nxt;
                            span_cnt_r  <= (addr_nxt == start_r) ? 7'h00 : span_cnt_r + 7'h01;
                            load_pend_r <= reading_r;
                        end
                    end
                    default: begin
                        state_r <= sasp_pkg::ST_IGNORE;
                    end
                endcase
            end
        end else if (fall) begin
            if (load_pend_r) begin
                load_pend_r <= 1'b0;
                tx_r <= (state_r == sasp_pkg::ST_URA) ? {5'h00, ura_r} : reg_read(addr_r);
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    assign wr_stb = byte_done & (state_r == sasp_pkg::ST_DATA) & ~reading_r;

    always_ff @(posedge clk) begin
        if (srst || (wr_stb && addr_r == sasp_pkg::REG_RESET_ADDR
                     && rx_byte == sasp_pkg::REG_RESET_CODE)) begin
            for (int i = 0; i < (1 << sasp_pkg::ADDR_W); i++) begin
                mem_r[i] <= sasp_pkg::REG_DEFAULT;
            end
        end else if (wr_stb && addr_r != sasp_pkg::RESULT_HI_ADDR
                     && addr_r != sasp_pkg::RESULT_LO_ADDR && addr_r != sasp_pkg::STATUS_ADDR) begin
            mem_r[addr_r] <= rx_byte;
        end
    end

    // ------------------------------------------------------------------
    // Two-entry result buffer, drained only between result reads
    // ------------------------------------------------------------------
    assign res_busy = reading_r & (state_r == sasp_pkg::ST_DATA)
                    & (addr_r == sasp_pkg::RESULT_HI_ADDR || addr_r == sasp_pkg::RESULT_LO_ADDR);
    assign push     = result_in_valid & result_in_ready;
    assign pop      = (cnt_r != 2'h0) & ~res_busy;
    assign cnt_nxt  = cnt_r + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r           <= 2'h0;
            wr_ptr_r        <= 1'b0;
            rd_ptr_r        <= 1'b0;
            result_in_ready <= 1'b0;
            res_r           <= '0;
        end else begin
            cnt_r           <= cnt_nxt;
            result_in_ready <= (cnt_nxt != 2'h2);
            if (push) begin
                buf_r[wr_ptr_r] <= result_in_data;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop) begin
                res_r    <= buf_r[rd_ptr_r];
                rd_ptr_r <= ~rd_ptr_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Ready signalling and status flag
    // ------------------------------------------------------------------
    assign rd_hi_msb = rise & res_busy & (addr_r == sasp_pkg::RESULT_HI_ADDR) & (bit_cnt_r == 3'h0);
    assign rd_lo_lsb = byte_done & res_busy & (addr_r == sasp_pkg::RESULT_LO_ADDR);

    always_ff @(posedge clk) begin
        if (srst) begin
            ready_low_r  <= 1'b1;
            pulse_pend_r <= 1'b0;
            pulse_cnt_r  <= 16'h0000;
        end else if (pop) begin
            if (!ready_low_r || pulse_pend_r) begin
                ready_low_r  <= 1'b1;
                pulse_pend_r <= 1'b1;
                pulse_cnt_r  <= PULSE_CYC;
            end else begin
                ready_low_r  <= 1'b0;
            end
        end else if (pulse_pend_r) begin
            pulse_cnt_r <= pulse_cnt_r - 16'h0001;
            if (pulse_cnt_r == 16'h0001) begin
                pulse_pend_r <= 1'b0;
                ready_low_r  <= 1'b0;
            end
        end else if (rd_lo_lsb) begin
            ready_low_r <= 1'b1;
        end
    end

    // Fresh flag: a new result wins over a read in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            fresh_n_r <= 1'b1;
        end else if (pop) begin
            fresh_n_r <= 1'b0;
        end else if (rd_hi_msb) begin
            fresh_n_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Shared output pin
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            shared_output_pin_o  <= 1'b1;
            shared_output_pin_oe <= 1'b0;
        end else begin
            shared_output_pin_oe <= ~cs_s;
            shared_output_pin_o  <= reading_r ? tx_r[7] : ready_low_r;
        end
    end
endmodule
`default_nettype wire

/* File: shared/sasp_pkg.sv */
// Constants and types shared by the sensor front-end serial register port
`default_nettype none
package sasp_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int URA_W  = 3;
    localparam int LRA_W  = 4;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [6:0] REG_RESET_ADDR   = 7'h00;
    localparam logic [6:0] SER_RST_ADDR     = 7'h02;
    localparam logic [6:0] STREAM_CTRL_ADDR = 7'h03;
    localparam logic [6:0] STATUS_ADDR      = 7'h18;
    localparam logic [6:0] RESULT_HI_ADDR   = 7'h1A;
    localparam logic [6:0] RESULT_LO_ADDR   = 7'h1B;
    localparam logic [6:0] ADDR_MAX         = 7'h7F;
    localparam logic [6:0] ADDR_ZERO        = 7'h00;
    localparam logic [6:0] ADDR_ONE         = 7'h01;
    localparam logic [7:0] REG_DEFAULT      = 8'h00;
    localparam logic [7:0] REG_RESET_CODE   = 8'hC3;
    localparam logic [7:0] SER_RST_ON       = 8'h01;
    localparam logic [2:0] URA_RESET        = 3'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int INST_READ_BIT = 7;
    localparam int INST_URA_BIT  = 4;
    localparam int SZ_HI         = 6;
    localparam int SZ_LO         = 5;
    localparam int LRA_HI        = 3;
    localparam int KIND_BIT      = 7;
    localparam int SPAN_HI       = 6;
    localparam int FRESH_BIT     = 6;
    localparam logic [1:0] SZ_STREAM = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SER_RST_ONES   = 73;
    localparam int CLK_KHZ        = 10000;
    localparam int READY_PULSE_NS = 1000;
    localparam int READY_PULSE_CYC_RAW = (READY_PULSE_NS * CLK_KHZ + 999999) / 1000000;
    localparam int READY_PULSE_CYC = (READY_PULSE_CYC_RAW < 1) ? 1 : READY_PULSE_CYC_RAW;

    // Protocol states
    typedef enum logic [1:0] {ST_INST, ST_URA, ST_DATA, ST_IGNORE} sasp_state_e;
endpackage
`default_nettype wire

/* File: verif/sasp_host_model.sv */
// Host controller model that frames and shifts serial transactions
`timescale 1ns/100ps
`default_nettype none
module sasp_host_model (
    input  wire logic clk,
    input  wire logic pin_level,
    output logic      chip_select_low,
    output logic      serial_clock,
    output logic      serial_data_in
);
    logic [7:0] rx;
    // Deselected, clock parked low
    initial begin
        chip_select_low = 1'b1;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic open_frame();
        @(posedge clk);
        chip_select_low <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // Park the clock, deselect, flip data so nothing stale stays
    task automatic close_frame();
        @(posedge clk);
        serial_clock <= 1'b0;
        repeat (4) @(posedge clk);
        chip_select_low <= 1'b1;
        serial_data_in <= ~serial_data_in;
        repeat (8) @(posedge clk);
    endtask
    // MSB first, data changes with the fall, read bit taken late in the high phase
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            serial_clock <= 1'b0;
            serial_data_in <= tx[i];
            repeat (4) @(posedge clk);
            serial_clock <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            rx[i] = pin_level;
        end
    endtask
    task automatic set_upper(input logic [2:0] u);
        open_frame();
        xfer(8'h10);
        xfer({5'h00, u});
        close_frame();
    endtask
    task automatic get_upper(output logic [2:0] u);
        open_frame();
        xfer(8'h90);
        xfer(8'h00);
        u = rx[2:0];
        close_frame();
    endtask
    // Data access of n bytes; frame stays open when keep is set
    task automatic access(input logic rd, input logic [6:0] a, input int n,
                          input logic [63:0] wd, output logic [63:0] rv, input logic keep);
        rv = 64'h0;
        set_upper(a[6:4]);
        open_frame();
        xfer({rd, (n > 2) ? sasp_pkg::SZ_STREAM : 2'(n - 1), 1'b0, a[3:0]});
        for (int k = 0; k < n; k++) begin
            xfer(rd ? 8'h00 : wd[63-8*k -: 8]);
            rv[63-8*k -: 8] = rx;
        end
        if (!keep) close_frame();
    endtask
endmodule
`default_nettype wire

/* File: verif/sasp_spi_port_monitor.sv */
// Port checker for the serial register port
`timescale 1ns/100ps
`default_nettype none
module sasp_spi_port_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic chip_select_low,
    input wire logic shared_output_pin_o,
    input wire logic shared_output_pin_oe,
    input wire logic result_in_valid,
    input wire logic result_in_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Pin enable tracks chip select after the synchroniser
    property p_oe_off;
        chip_select_low [*5] |-> !shared_output_pin_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven while deselected");
    property p_oe_on;
        !chip_select_low [*5] |-> shared_output_pin_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin idle while selected");
    property p_oe_lag;
        $fell(chip_select_low) |=> !shared_output_pin_oe;
    endproperty
    a_oe_lag: assert property (p_oe_lag) else $error("pin enable ahead of select");
    property p_oe_drop;
        $rose(chip_select_low) |-> ##[2:5] !shared_output_pin_oe;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("pin enable stuck on");
    // Outputs leaving reset: ready pin released, buffer opens one cycle later
    property p_reset_out;
        $fell(srst) |-> shared_output_pin_o && !shared_output_pin_oe && !result_in_ready;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("bad outputs at reset exit");
    property p_room_after;
        $fell(srst) |=> result_in_ready;
    endproperty
    a_room_after: assert property (p_room_after) else $error("buffer closed after reset");
    // Buffer fills only by pushes
    property p_full_cause;
        $fell(result_in_ready) |-> $past(result_in_valid);
    endproperty
    a_full_cause: assert property (p_full_cause) else $error("buffer full without push");
    property p_room_hold;
        result_in_ready && !result_in_valid |=> result_in_ready;
    endproperty
    a_room_hold: assert property (p_room_hold) else $error("room lost without push");
endmodule
bind sasp_spi_port sasp_spi_port_monitor i_sasp_spi_port_monitor (
    .clk(clk), .srst(srst), .chip_select_low(chip_select_low),
    .shared_output_pin_o(shared_output_pin_o), .shared_output_pin_oe(shared_output_pin_oe),
    .result_in_valid(result_in_valid), .result_in_ready(result_in_ready));
`default_nettype wire

/* File: verif/sasp_spi_port_tb.sv */
// Self-checking bench for the serial register port
`timescale 1ns/100ps
`default_nettype none
module sasp_spi_port_tb;
    logic        clk, srst, valid, tgl;
    logic [15:0] data;
    logic [63:0] rv;
    logic [2:0]  u;
    int          errors, checked, cycles, cnt;
    wire logic   cs, sclk, sdi, pin_o, oe, ready, pin_level;
    assign pin_level = oe ? pin_o : tgl;
    sasp_spi_port #(.RES_W(16)) i_sasp_spi_port (.clk(clk), .srst(srst),
        .chip_select_low(cs), .serial_clock(sclk), .serial_data_in(sdi),
        .shared_output_pin_o(pin_o), .shared_output_pin_oe(oe), .result_in_valid(valid),
        .result_in_data(data), .result_in_ready(ready));
    sasp_host_model i_sasp_host_model (.clk(clk), .pin_level(pin_level),
        .chip_select_low(cs), .serial_clock(sclk), .serial_data_in(sdi));
    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Changing level on the released pin, and hang guard
    always @(posedge clk) begin
        tgl <= ~tgl;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pin_chk(input logic e);
        @(negedge clk);
        cmp("ready pin", {31'h0, e}, {31'h0, pin_level});
    endtask
    task automatic wr(input logic [6:0] a, input int n, input logic [63:0] wd);
        i_sasp_host_model.access(1'b0, a, n, wd, rv, 1'b0);
    endtask
    task automatic rd(input logic [6:0] a, input int n, input logic keep);
        i_sasp_host_model.access(1'b1, a, n, 64'h0, rv, keep);
    endtask
    task automatic push(input logic [15:0] d);
        @(posedge clk);
        valid <= 1'b1;
        data <= d;
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        valid <= 1'b0;
    endtask
    task automatic ones(input int n);
        i_sasp_host_model.open_frame();
        repeat (n) i_sasp_host_model.xfer(8'hFF);
        i_sasp_host_model.close_frame();
    endtask
    // Register access, refused write, serial reset still off
    task automatic t_regs();
        rd(7'h18, 1, 1'b0);
        cmp("fresh flag", 32'h40, rv[63:56] & 8'h40);
        rd(7'h02, 1, 1'b0);
        cmp("serial reset reg", 32'h00, rv[63:56]);
        wr(7'h02, 1, {8'hAA, 56'h0});
        wr(7'h1A, 1, {8'hFF, 56'h0});
        rd(7'h02, 1, 1'b0);
        cmp("serial reset reg", 32'hAA, rv[63:56]);
        rd(7'h1A, 1, 1'b0);
        cmp("result high", 32'h00, rv[63:56]);
        i_sasp_host_model.set_upper(3'h3);
        ones(10);
        i_sasp_host_model.get_upper(u);
        cmp("upper kept", 32'h3, u);
        $display("test regs done");
    endtask
    // Normal and controlled streams with address wrap
    task automatic t_stream();
        wr(7'h7D, 5, {40'h1122330044, 24'h0});
        i_sasp_host_model.get_upper(u);
        cmp("upper after stream", 32'h7, u);
        rd(7'h7E, 4, 1'b0);
        cmp("normal stream", 32'h22330044, rv[63:32]);
        wr(7'h03, 1, {8'h81, 56'h0});
        wr(7'h04, 3, {24'hA1B2C3, 40'h0});
        rd(7'h04, 4, 1'b0);
        cmp("controlled stream", 32'hC3B2C3B2, rv[63:32]);
        wr(7'h03, 1, 64'h0);
        rd(7'h06, 1, 1'b0);
        cmp("past span", 32'h00, rv[63:56]);
        $display("test stream done");
    endtask
    // Result read, ready pin and status copy
    task automatic t_result();
        push(16'hA5C3);
        i_sasp_host_model.open_frame();
        pin_chk(1'b0);
        i_sasp_host_model.close_frame();
        rd(7'h18, 1, 1'b0);
        cmp("fresh flag", 32'h00, rv[63:56] & 8'h40);
        rd(7'h1A, 2, 1'b1);
        cmp("result", 32'hA5C3, rv[63:48]);
        repeat (10) @(posedge clk);
        pin_chk(1'b1);
        i_sasp_host_model.close_frame();
        cmp("pin enable", 32'h0, oe);
        rd(7'h18, 1, 1'b0);
        cmp("fresh flag", 32'h40, rv[63:56] & 8'h40);
        $display("test result done");
    endtask
    // Result over an unread one, partial read, register reset
    task automatic t_pulse();
        push(16'h1234);
        i_sasp_host_model.open_frame();
        pin_chk(1'b0);
        push(16'h5678);
        cnt = 0;
        repeat (40) begin
            @(negedge clk);
            if (pin_level === 1'b1) cnt++;
        end
        cmp("pulse length", sasp_pkg::READY_PULSE_CYC, cnt);
        pin_chk(1'b0);
        i_sasp_host_model.close_frame();
        rd(7'h1A, 1, 1'b0);
        cmp("new result", 32'h56, rv[63:56]);
        rd(7'h18, 1, 1'b0);
        cmp("fresh flag", 32'h40, rv[63:56] & 8'h40);
        i_sasp_host_model.open_frame();
        pin_chk(1'b0);
        i_sasp_host_model.close_frame();
        push(16'h9ABC);
        wr(7'h00, 1, {sasp_pkg::REG_RESET_CODE, 56'h0});
        rd(7'h18, 1, 1'b0);
        cmp("fresh flag", 32'h00, rv[63:56] & 8'h40);
        $display("test pulse done");
    endtask
    // No serial reset after 72 ones, serial reset by 80 ones
    task automatic t_sreset();
        wr(7'h02, 1, {sasp_pkg::SER_RST_ON, 56'h0});
        for (int n = 9; n <= 10; n++) begin
            i_sasp_host_model.set_upper(3'h5);
            ones(n);
            i_sasp_host_model.get_upper(u);
            cmp("upper after ones", (n == 10) ? 32'h0 : 32'h5, u);
        end
        rd(7'h02, 1, 1'b0);
        cmp("serial reset reg", 32'h01, rv[63:56]);
        $display("test serial reset done");
    endtask
    // Results arriving during a result read, then a reset in mid-run
    task automatic t_stall();
        fork
            rd(7'h1A, 2, 1'b0);
            begin
                repeat (270) @(posedge clk);
                push(16'h1357);
                push(16'h2468);
                @(negedge clk);
                cmp("input ready", 32'h0, ready);
            end
        join
        cmp("result during read", 32'h9ABC, rv[63:48]);
        rd(7'h1A, 2, 1'b0);
        cmp("result after read", 32'h2468, rv[63:48]);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        rd(7'h02, 1, 1'b0);
        cmp("serial reset reg", 32'h00, rv[63:56]);
        rd(7'h18, 1, 1'b0);
        cmp("fresh flag", 32'h40, rv[63:56] & 8'h40);
        $display("test stall done");
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        valid = 1'b0;
        data = 16'h0000;
        tgl = 1'b0;
        {errors, checked, cycles} = '0;
        repeat (20) @(posedge clk);
        cmp("reset outputs", 32'h2, {oe, pin_o, ready});
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        t_regs();
        t_stream();
        t_result();
        t_pulse();
        t_sreset();
        t_stall();
        conclude();
    end
endmodule
`default_nettype wire
